// [rtl/i2c_gc_pkg.sv]
package i2c_gc_pkg;
	// mode select codes recognised by this port
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_SLAVE7 = 4'h6;
	localparam logic [3:0] MODE_SLAVE10 = 4'h7;
	// fixed general call address, all zeros with write direction
	localparam logic [7:0] GCALL_ADDR = 8'h00;
	// bit positions inside a byte frame
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] AFTER_ACK = 4'h9;
	localparam logic [3:0] FIRST_BIT = 4'h0;
	// reset values
	localparam logic [6:0] BAUD_RST = 7'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// core cycles the link side stays in reset after release
	localparam logic [5:0] LINK_RST_CYC = 6'h30;

	// commands carried from the software side to the link side
	typedef enum logic [2:0] {
		CMD_START = 3'h0,
		CMD_RSTART = 3'h1,
		CMD_STOP = 3'h2,
		CMD_RECV = 3'h3,
		CMD_ACK = 3'h4,
		CMD_SEND = 3'h5
	} cmd_t;

	// events carried from the link side back
	typedef enum logic [2:0] {
		EV_START = 3'h0,
		EV_STOP = 3'h1,
		EV_TXDONE = 3'h2,
		EV_RXDONE = 3'h3,
		EV_ACKDONE = 3'h4,
		EV_SLV_UPD = 3'h5,
		EV_SLV_BYTE = 3'h6,
		EV_SLV_IRQ = 3'h7
	} evt_t;

	// master sequencer states
	typedef enum logic [3:0] {
		M_IDLE = 4'h0,
		M_ST_A = 4'h1,
		M_ST_B = 4'h2,
		M_RS_LOW = 4'h3,
		M_RS_HIGH = 4'h4,
		M_BIT_LOW = 4'h5,
		M_BIT_HIGH = 4'h6,
		M_SP_LOW = 4'h7,
		M_SP_HIGH = 4'h8,
		M_SP_REL = 4'h9
	} mst_t;

	typedef struct packed {
		logic port_enable_bit;
		logic [3:0] port_mode_select;
		logic general_call_enable;
		logic ten_bit_mode;
		logic [7:0] own_address_or_reload;
	} cfg_t;

	typedef struct packed {
		logic start_req;
		logic rstart_req;
		logic stop_req;
		logic recv_req;
		logic ack_req;
		logic ack_value;
		logic buf_wr;
		logic buf_rd;
		logic addr_wr;
		logic clr_intr;
		logic clr_write_collision_flag;
		logic [7:0] wdata;
	} sw_req_t;

	typedef struct packed {
		logic [7:0] serial_data_buffer;
		logic buffer_full_flag;
		logic port_interrupt_flag;
		logic write_collision_flag;
		logic update_address_flag;
		logic ack_status;
		logic start_request_bit;
		logic stop_request_bit;
		logic start_seen;
		logic stop_seen;
	} status_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} pins_t;
endpackage

// [rtl/i2c_master_gencall_brg.sv]
`timescale 1ns/1ps
module i2c_master_gencall_brg (
	// core clock, reset and link clock
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	// software configuration and requests
	input i2c_gc_pkg::cfg_t cfg,
	input i2c_gc_pkg::sw_req_t req,
	// software status
	output i2c_gc_pkg::status_t status,
	// two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe
);
	import i2c_gc_pkg::*;

	// core side state
	typedef struct packed {
		status_t st;
		cmd_t cmd;
		logic [7:0] txd;
		logic cmd_tgl;
		logic busy;
		logic [2:0] ev_sy;
		logic [1:0] s_sy;
		logic [1:0] p_sy;
		logic [5:0] rst_cnt; // reset stretch for the link side
		logic link_run; // link side may leave reset
	} core_t;

	// link side state
	typedef struct packed {
		logic [1:0] rst_sy;
		logic [2:0] cmd_sy;
		cfg_t cfg1;
		cfg_t cfg2;
		logic [1:0] full_sy;
		pins_t pin1;
		pins_t pin2;
		pins_t pin3;
		mst_t ms;
		logic [6:0] baud_cnt;
		logic armed;
		logic [3:0] bitn;
		logic [7:0] sr;
		cmd_t op;
		logic scl_oe;
		logic sda_oe;
		logic s_seen;
		logic p_seen;
		logic ev_tgl;
		evt_t ev;
		logic [7:0] ev_data;
		logic ev_ack;
		logic sact;
		logic saddr;
		logic sack;
		logic [3:0] sbit;
		logic [7:0] ssr;
	} link_t;

	core_t c, cn;
	link_t l, ln;

	// software side: requests, flags and event intake
	always_comb begin
		logic master;
		logic go;
		cmd_t gcmd;
		logic ev_new;
		cn = c;
		go = 1'b0;
		gcmd = CMD_START;
		master = cfg.port_enable_bit && cfg.port_mode_select == MODE_MASTER;
		cn.ev_sy = {c.ev_sy[1:0], l.ev_tgl};
		cn.s_sy = {c.s_sy[0], l.s_seen};
		cn.p_sy = {c.p_sy[0], l.p_seen};
		// a short core reset would slip past the slow link clock
		cn.link_run = c.rst_cnt == LINK_RST_CYC;
		if (!cn.link_run) begin
			cn.rst_cnt = c.rst_cnt + 6'h01;
		end
		ev_new = c.ev_sy[2] ^ c.ev_sy[1];
		cn.st.start_seen = c.s_sy[1];
		cn.st.stop_seen = c.p_sy[1];
		// software clears first so a same-cycle set wins
		if (req.clr_intr) begin
			cn.st.port_interrupt_flag = 1'b0;
		end
		if (req.clr_write_collision_flag) begin
			cn.st.write_collision_flag = 1'b0;
		end
		if (req.buf_rd) begin
			cn.st.buffer_full_flag = 1'b0;
		end
		if (req.addr_wr) begin
			cn.st.update_address_flag = 1'b0;
		end
		if (master) begin
			if (req.buf_wr && c.busy) begin
				cn.st.write_collision_flag = 1'b1;
			end else if (!c.busy) begin
				// one request at a time, nothing is queued
				if (req.start_req) begin
					go = 1'b1;
					gcmd = CMD_START;
					cn.st.start_request_bit = 1'b1;
				end else if (req.rstart_req) begin
					go = 1'b1;
					gcmd = CMD_RSTART;
				end else if (req.stop_req) begin
					go = 1'b1;
					gcmd = CMD_STOP;
					cn.st.stop_request_bit = 1'b1;
				end else if (req.recv_req) begin
					go = 1'b1;
					gcmd = CMD_RECV;
				end else if (req.ack_req) begin
					go = 1'b1;
					gcmd = CMD_ACK;
					cn.txd = {req.ack_value, 7'h00};
				end else if (req.buf_wr) begin
					go = 1'b1;
					gcmd = CMD_SEND;
					cn.txd = req.wdata;
					cn.st.serial_data_buffer = req.wdata;
					cn.st.buffer_full_flag = 1'b1;
				end
			end
		end else if (req.buf_wr) begin
			// slave side: buffer simply takes the write
			cn.st.serial_data_buffer = req.wdata;
		end
		if (go) begin
			cn.cmd = gcmd;
			cn.cmd_tgl = ~c.cmd_tgl;
			cn.busy = 1'b1;
		end
		// event word is stable while its toggle crosses
		if (ev_new) begin
			unique case (l.ev)
				EV_START: begin
					cn.busy = 1'b0;
					cn.st.start_request_bit = 1'b0;
					cn.st.port_interrupt_flag = 1'b1;
				end
				EV_STOP: begin
					cn.busy = 1'b0;
					cn.st.stop_request_bit = 1'b0;
					cn.st.port_interrupt_flag = 1'b1;
				end
				EV_TXDONE: begin
					cn.busy = 1'b0;
					cn.st.ack_status = l.ev_ack;
					cn.st.buffer_full_flag = 1'b0;
					cn.st.port_interrupt_flag = 1'b1;
				end
				EV_RXDONE: begin
					cn.busy = 1'b0;
					cn.st.serial_data_buffer = l.ev_data;
					cn.st.buffer_full_flag = 1'b1;
					cn.st.port_interrupt_flag = 1'b1;
				end
				EV_ACKDONE: begin
					cn.busy = 1'b0;
					cn.st.port_interrupt_flag = 1'b1;
				end
				EV_SLV_UPD: begin
					// own ten-bit match asks for new address
					cn.st.serial_data_buffer = l.ev_data;
					cn.st.buffer_full_flag = 1'b1;
					cn.st.update_address_flag = 1'b1;
				end
				EV_SLV_BYTE: begin
					cn.st.serial_data_buffer = l.ev_data;
					cn.st.buffer_full_flag = 1'b1;
				end
				EV_SLV_IRQ: begin
					cn.st.port_interrupt_flag = 1'b1;
				end
			endcase
		end
		if (!cfg.port_enable_bit) begin
			cn.busy = 1'b0;
			cn.st.start_request_bit = 1'b0;
			cn.st.stop_request_bit = 1'b0;
		end
	end

	// core register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			c <= '0;
		end else begin
			c <= cn;
		end
	end

	// link side: pin sampling, baud count, master and slave
	always_comb begin
		logic scl, sda, srise, sfall, bstart, bstop;
		logic master, slave, done, cmd_new, emit, last, hit, gc;
		evt_t ecode;
		logic [7:0] edata, sbyte;
		logic [6:0] reload;
		ln = l;
		emit = 1'b0;
		ecode = EV_START;
		edata = l.sr;
		last = 1'b0;
		hit = 1'b0;
		gc = 1'b0;
		sbyte = {l.ssr[6:0], l.pin2.sda};
		ln.cmd_sy = {l.cmd_sy[1:0], c.cmd_tgl};
		ln.cfg1 = cfg;
		ln.cfg2 = l.cfg1;
		ln.full_sy = {l.full_sy[0], c.st.buffer_full_flag};
		ln.pin1 = '{scl: scl_in, sda: sda_in};
		ln.pin2 = l.pin1;
		ln.pin3 = l.pin2;
		scl = l.pin2.scl;
		sda = l.pin2.sda;
		srise = scl && !l.pin3.scl;
		sfall = !scl && l.pin3.scl;
		bstart = scl && l.pin3.scl && !sda && l.pin3.sda;
		bstop = scl && l.pin3.scl && sda && !l.pin3.sda;
		cmd_new = l.cmd_sy[2] ^ l.cmd_sy[1];
		master = l.cfg2.port_enable_bit &&
			l.cfg2.port_mode_select == MODE_MASTER;
		slave = l.cfg2.port_enable_bit &&
			(l.cfg2.port_mode_select == MODE_SLAVE7 ||
			l.cfg2.port_mode_select == MODE_SLAVE10);
		// reload from the low seven bits
		reload = l.cfg2.own_address_or_reload[6:0];
		// one step per tick, halts at zero
		done = l.baud_cnt == BAUD_RST;
		if (!done) begin
			ln.baud_cnt = l.baud_cnt - 7'h01;
		end
		// bus condition tracking
		if (bstart) begin
			ln.s_seen = 1'b1;
			ln.p_seen = 1'b0;
		end else if (bstop) begin
			ln.s_seen = 1'b0;
			ln.p_seen = 1'b1;
		end
		// pins are only ever pulled low or let go
		unique case (l.ms)
			M_IDLE: begin
				// clock line left as the last step set it
				if (cmd_new && master) begin
					ln.op = c.cmd;
					ln.armed = 1'b0;
					ln.baud_cnt = reload;
					unique case (c.cmd)
						CMD_START: ln.ms = M_ST_A;
						CMD_RSTART: begin
							ln.scl_oe = 1'b1;
							ln.ms = M_RS_LOW;
						end
						CMD_STOP: begin
							ln.scl_oe = 1'b1;
							ln.sda_oe = 1'b1;
							ln.ms = M_SP_LOW;
						end
						CMD_RECV: begin
							ln.bitn = FIRST_BIT;
							ln.scl_oe = 1'b1;
							ln.sda_oe = 1'b0;
							ln.ms = M_BIT_LOW;
						end
						CMD_ACK: begin
							// single bit, driven value from software
							ln.sr = c.txd;
							ln.bitn = ACK_SLOT;
							ln.scl_oe = 1'b1;
							ln.sda_oe = ~c.txd[7];
							ln.ms = M_BIT_LOW;
						end
						CMD_SEND: begin
							// address byte goes out as written
							ln.sr = c.txd;
							ln.bitn = FIRST_BIT;
							ln.scl_oe = 1'b1;
							ln.sda_oe = ~c.txd[7];
							ln.ms = M_BIT_LOW;
						end
					endcase
				end
			end
			M_ST_A: begin
				// both lines high for one period
				if (done) begin
					ln.baud_cnt = reload;
					if (scl && sda) begin
						ln.sda_oe = 1'b1;
						ln.ms = M_ST_B;
					end
				end
			end
			M_ST_B: begin
				// hold data low a full period, then finish
				if (done) begin
					emit = 1'b1;
					ecode = EV_START;
					ln.ms = M_IDLE;
				end
			end
			M_RS_LOW: begin
				ln.sda_oe = 1'b0;
				if (!scl && !l.armed) begin
					ln.baud_cnt = reload;
					ln.armed = 1'b1;
				end else if (l.armed && done) begin
					ln.scl_oe = 1'b0;
					ln.armed = 1'b0;
					ln.ms = M_RS_HIGH;
				end
			end
			M_RS_HIGH: begin
				if (scl && !l.armed) begin
					ln.baud_cnt = reload;
					ln.armed = 1'b1;
				end else if (l.armed && done && scl && sda) begin
					ln.sda_oe = 1'b1;
					ln.baud_cnt = reload;
					ln.ms = M_ST_B;
				end
			end
			M_BIT_LOW: begin
				if (done) begin
					ln.scl_oe = 1'b0;
					ln.armed = 1'b0;
					ln.ms = M_BIT_HIGH;
				end
			end
			M_BIT_HIGH: begin
				// count only once clock is seen high
				if (scl && !l.armed) begin
					ln.baud_cnt = reload;
					ln.armed = 1'b1;
				end else if (l.armed && done) begin
					ln.sr = {l.sr[6:0], sda};
					ln.bitn = l.bitn + 4'h1;
					ln.scl_oe = 1'b1;
					ln.baud_cnt = reload;
					last = (l.op == CMD_SEND && l.bitn == ACK_SLOT) ||
						(l.op == CMD_RECV && l.bitn == LAST_DATA_BIT) ||
						l.op == CMD_ACK;
					if (last) begin
						emit = 1'b1;
						ecode = l.op == CMD_SEND ? EV_TXDONE :
							l.op == CMD_RECV ? EV_RXDONE : EV_ACKDONE;
						edata = {l.sr[6:0], sda};
						ln.sda_oe = 1'b0;
						ln.ms = M_IDLE;
					end else begin
						// next bit set up in the same cycle the clock is pulled low
						ln.sda_oe = l.op == CMD_SEND &&
							l.bitn != LAST_DATA_BIT && !l.sr[6];
						ln.ms = M_BIT_LOW;
					end
				end
			end
			M_SP_LOW: begin
				if (done) begin
					ln.scl_oe = 1'b0;
					ln.armed = 1'b0;
					ln.ms = M_SP_HIGH;
				end
			end
			M_SP_HIGH: begin
				if (scl && !l.armed) begin
					ln.baud_cnt = reload;
					ln.armed = 1'b1;
				end else if (l.armed && done) begin
					ln.sda_oe = 1'b0;
					ln.baud_cnt = reload;
					ln.ms = M_SP_REL;
				end
			end
			M_SP_REL: begin
				if (done) begin
					emit = 1'b1;
					ecode = EV_STOP;
					ln.ms = M_IDLE;
				end
			end
			default: ln.ms = M_IDLE;
		endcase
		// slave address and data intake
		if (slave) begin
			if (bstart) begin
				ln.sact = 1'b1;
				ln.saddr = 1'b0;
				ln.sack = 1'b0;
				ln.sbit = FIRST_BIT;
				ln.sda_oe = 1'b0;
			end else if (bstop) begin
				ln.sact = 1'b0;
				ln.sda_oe = 1'b0;
			end else if (l.sact && srise) begin
				if (l.sbit <= LAST_DATA_BIT) begin
					ln.ssr = sbyte;
					ln.sbit = l.sbit + 4'h1;
				end else begin
					ln.sbit = AFTER_ACK;
				end
				if (l.sbit == LAST_DATA_BIT) begin
					gc = l.cfg2.general_call_enable && sbyte == GCALL_ADDR;
					hit = sbyte[7:1] ==
						l.cfg2.own_address_or_reload[7:1];
					if (l.saddr || gc || hit) begin
						ln.sack = !l.full_sy[1];
						ln.saddr = 1'b1;
						emit = 1'b1;
						edata = sbyte;
						// general call never needs second half
						ecode = (!l.saddr && hit && !gc &&
							l.cfg2.ten_bit_mode) ? EV_SLV_UPD : EV_SLV_BYTE;
					end else begin
						ln.sact = 1'b0;
					end
				end
			end else if (l.sact && sfall) begin
				if (l.sbit == ACK_SLOT && l.sack) begin
					ln.sda_oe = 1'b1;
				end else if (l.sbit == AFTER_ACK) begin
					ln.sda_oe = 1'b0;
					ln.sbit = FIRST_BIT;
					emit = l.saddr;
					ecode = EV_SLV_IRQ;
				end
			end
		end else if (!master) begin
			ln.sact = 1'b0;
			ln.ms = M_IDLE;
			ln.scl_oe = 1'b0;
			ln.sda_oe = 1'b0;
		end
		if (emit) begin
			ln.ev_tgl = ~l.ev_tgl;
			ln.ev = ecode;
			ln.ev_data = edata;
			ln.ev_ack = sda;
		end
		if (!l.cfg2.port_enable_bit) begin
			ln.s_seen = 1'b0;
			ln.p_seen = 1'b0;
		end
		// stretched reset is released into this domain by its own pair
		ln.rst_sy = {l.rst_sy[0], c.link_run};
		if (!l.rst_sy[1]) begin
			ln = '0;
			ln.rst_sy = {l.rst_sy[0], c.link_run};
		end
	end

	// link register, reset follows the synchronised reset
	always_ff @(posedge link_clk) begin
		l <= ln;
	end

	// outputs straight from flip-flops
	assign status = c.st;
	assign scl_oe = l.scl_oe;
	assign sda_oe = l.sda_oe;
	assign scl_out = l.ev_data[0] & 1'b0;
	assign sda_out = l.ev_data[0] & 1'b0;
endmodule // i2c_master_gencall_brg

// [tb/i2c_master_gencall_brg_properties.sv]
`timescale 1ns/1ps
module i2c_master_gencall_brg_properties (
	// clocks and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	// software side
	input i2c_gc_pkg::cfg_t cfg,
	input i2c_gc_pkg::sw_req_t req,
	input i2c_gc_pkg::status_t status,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe
);
	import i2c_gc_pkg::*;
	logic mst; // port enabled as master
	assign mst = cfg.port_enable_bit && cfg.port_mode_select == MODE_MASTER;
	// start asked while nothing visible is running
	sequence s_start_ask;
		req.start_req && mst && !status.start_request_bit
			&& !status.stop_request_bit && !status.buffer_full_flag;
	endsequence
	// start request retired by hardware
	sequence s_start_end;
		$fell(status.start_request_bit);
	endsequence
	property p_pins_low;
		@(posedge clk) disable iff (!rstn) !scl_out && !sda_out;
	endproperty
	a_pins_low: assert property (p_pins_low)
		else $error("pin driven high");
	property p_rst_clear;
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> !status.start_seen && !status.stop_seen;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("seen flags after reset");
	property p_dis_clear;
		@(posedge clk) disable iff (!rstn) $fell(cfg.port_enable_bit)
		|-> ##[1:80] (!status.start_seen && !status.stop_seen);
	endproperty
	a_dis_clear: assert property (p_dis_clear)
		else $error("seen flags after disable");
	property p_write_collision_flag;
		@(posedge clk) disable iff (!rstn)
		req.buf_wr && status.start_request_bit && mst |=>
			status.write_collision_flag && $stable(status.serial_data_buffer);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag)
		else $error("early write not refused");
	property p_start_req;
		@(posedge clk) disable iff (!rstn)
		s_start_ask |-> ##[1:2] status.start_request_bit;
	endproperty
	a_start_req: assert property (p_start_req)
		else $error("start request not shown");
	property p_start_irq;
		@(posedge clk) disable iff (!rstn)
		s_start_end |-> ##[0:4] status.port_interrupt_flag;
	endproperty
	a_start_irq: assert property (p_start_irq)
		else $error("no flag after start");
	property p_start_hold;
		@(posedge clk) disable iff (!rstn) s_start_end |-> sda_oe;
	endproperty
	a_start_hold: assert property (p_start_hold)
		else $error("data not held low after start");
	property p_stop_irq;
		@(posedge clk) disable iff (!rstn) $fell(status.stop_request_bit)
		|-> (!scl_oe && !sda_oe) ##[0:4] status.port_interrupt_flag;
	endproperty
	a_stop_irq: assert property (p_stop_irq)
		else $error("stop not finished cleanly");
	property p_tx_end;
		@(posedge clk) disable iff (!rstn) $fell(status.buffer_full_flag)
		&& !$past(req.buf_rd) && mst |-> scl_oe;
	endproperty
	a_tx_end: assert property (p_tx_end)
		else $error("clock not held after byte");
	property p_high_time;
		@(posedge link_clk) disable iff (!rstn)
		$rose(scl_in) |=> !scl_oe [*2];
	endproperty
	a_high_time: assert property (p_high_time)
		else $error("clock high time cut short");
	property p_slave_scl;
		@(posedge link_clk) disable iff (!rstn)
		!mst && $stable(cfg) |-> !scl_oe;
	endproperty
	a_slave_scl: assert property (p_slave_scl)
		else $error("clock driven outside master");
endmodule // i2c_master_gencall_brg_properties

bind i2c_master_gencall_brg i2c_master_gencall_brg_properties props (
	.clk(clk), .rstn(rstn), .link_clk(link_clk), .cfg(cfg), .req(req),
	.status(status), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

// [tb/i2c_slave_model.sv]
`timescale 1ns/1ps
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// wired bus levels
	input wire logic scl,
	input wire logic sda,
	// behaviour controls
	input wire logic stretch,
	input wire logic [7:0] rd_byte,
	// pull-low enables
	output logic sda_oe,
	output logic scl_oe
);
	logic [7:0] sh; // bits taken from the bus
	int bitn = 0;
	logic act = 1'b0;
	logic rd = 1'b0;
	logic first = 1'b0;
	initial begin
		sda_oe = 1'b0;
		scl_oe = 1'b0;
	end
	// start or repeated start restarts the frame
	always @(negedge sda) begin
		// a clock fall in the same step must not look like a start
		#1;
		if (scl && !sda) begin
			bitn = 0;
			act = 1'b1;
			first = 1'b1;
			rd = 1'b0;
		end
	end
	// stop ends the frame
	always @(posedge sda) begin
		#1;
		if (scl && sda) begin
			act = 1'b0;
		end
	end
	always @(posedge scl) begin
		if (act) begin
			if (bitn < 8) begin
				sh = {sh[6:0], sda};
			end
			bitn = bitn + 1;
			// master declined more data
			if (bitn == 9 && rd && sda) begin
				act = 1'b0;
			end
		end
	end
	// changes only while the clock is low
	always @(negedge scl) begin
		if (act) begin
			sda_oe = 1'b0;
			if (bitn == 9) begin
				bitn = 0;
			end
			if (bitn == 8) begin
				sda_oe = first ? (sh[7:1] == ADDR) : !rd;
				act = !first || (sh[7:1] == ADDR);
				rd = first ? sh[0] : rd;
				first = 1'b0;
			end else if (rd) begin
				sda_oe = !rd_byte[3'(7 - bitn)];
			end
			// slow device holds the clock low
			if (stretch && bitn < 8) begin
				scl_oe = 1'b1;
				#500;
				scl_oe = 1'b0;
			end
		end
	end
endmodule // i2c_slave_model

// [tb/test_i2c_master_gencall_brg.sv]
`timescale 1ns/1ps
module test_i2c_master_gencall_brg;
	import i2c_gc_pkg::*;
	logic clk, rstn, link_clk, stretch, tb_scl_oe, tb_sda_oe;
	cfg_t cfg;
	sw_req_t req;
	status_t status;
	logic scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	// wired-and bus with pull-ups
	wire scl = !(scl_oe | s_scl_oe | tb_scl_oe);
	wire sda = !(sda_oe | s_sda_oe | tb_sda_oe);
	i2c_master_gencall_brg dut (.clk(clk), .rstn(rstn), .link_clk(link_clk),
		.cfg(cfg), .req(req), .status(status), .scl_in(scl), .sda_in(sda),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
		.sda_oe(sda_oe));
	i2c_slave_model #(.ADDR(7'h2a)) far (.scl(scl), .sda(sda),
		.stretch(stretch), .rd_byte(8'ha5), .sda_oe(s_sda_oe),
		.scl_oe(s_scl_oe));
	initial begin
		clk = 1'b0;
		forever #4 clk = !clk;
	end
	// link clock, phase unrelated
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #62.5 link_clk = !link_clk;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// end a one-cycle request pulse
	task automatic drop();
		tick(1);
		req = '0;
		// let an edge pass before the next request
		tick(1);
	endtask
	// wait for the port flag, then clear it
	task automatic done();
		int n;
		n = 0;
		while (status.port_interrupt_flag !== 1'b1 && n < 5000) begin
			tick(1);
			n++;
		end
		chk(8'(status.port_interrupt_flag), 8'h01);
		req.clr_intr = 1'b1;
		drop();
	endtask
	task automatic send(input logic [7:0] b, input logic [7:0] ack);
		req.buf_wr = 1'b1;
		req.wdata = b;
		drop();
		tick(1);
		chk(8'(status.buffer_full_flag), 8'h01);
		done();
		chk(8'(status.ack_status), ack);
		chk(8'(status.buffer_full_flag), 8'h00);
	endtask
	task automatic t_master();
		// idle bus may be taken
		chk(8'({status.start_seen, status.stop_seen}), 8'h00);
		req.start_req = 1'b1;
		drop();
		tick(1);
		chk(8'(status.start_request_bit), 8'h01);
		req.buf_wr = 1'b1;
		req.wdata = 8'h77;
		drop();
		tick(1);
		chk(8'(status.write_collision_flag), 8'h01);
		chk(status.serial_data_buffer, 8'h00);
		done();
		chk(8'({status.start_request_bit, status.start_seen, sda_oe}), 8'h03);
		send(8'h54, 8'h00);
		chk(8'(scl_oe), 8'h01);
		stretch = 1'b1;
		send(8'h3c, 8'h00);
		stretch = 1'b0;
		req.rstart_req = 1'b1;
		drop();
		done();
		send(8'ha0, 8'h01);
		req.rstart_req = 1'b1;
		drop();
		done();
		send(8'h55, 8'h00);
		req.recv_req = 1'b1;
		drop();
		done();
		chk(status.serial_data_buffer, 8'ha5);
		req.buf_rd = 1'b1;
		drop();
		req.ack_req = 1'b1;
		req.ack_value = 1'b1;
		drop();
		done();
		req.stop_req = 1'b1;
		drop();
		tick(1);
		chk(8'(status.stop_request_bit), 8'h01);
		done();
		chk(8'({status.stop_request_bit, status.stop_seen}), 8'h01);
		chk(8'({scl, sda}), 8'h03);
	endtask
	// bench plays another master on the wire
	task automatic gframe(input logic [7:0] b, input logic acked);
		logic seen;
		tb_sda_oe = 1'b1;
		#1000;
		for (int i = 7; i >= 0; i--) begin
			tb_scl_oe = 1'b1;
			#500;
			tb_sda_oe = !b[i];
			#500;
			tb_scl_oe = 1'b0;
			#1000;
		end
		tb_scl_oe = 1'b1;
		tb_sda_oe = 1'b0;
		#1000;
		tb_scl_oe = 1'b0;
		#500;
		seen = !sda;
		#500;
		tb_scl_oe = 1'b1;
		#500;
		tb_sda_oe = 1'b1;
		#500;
		tb_scl_oe = 1'b0;
		#500;
		tb_sda_oe = 1'b0;
		#1000;
		chk(8'(seen), 8'(acked));
	endtask
	task automatic sclr();
		req.buf_rd = 1'b1;
		req.clr_intr = 1'b1;
		req.addr_wr = 1'b1;
		drop();
	endtask
	task automatic t_slave();
		cfg = '{1'b1, MODE_SLAVE7, 1'b1, 1'b0, 8'h64};
		gframe(8'h00, 1'b1);
		chk(status.serial_data_buffer, 8'h00);
		chk(8'({status.buffer_full_flag, status.port_interrupt_flag}), 8'h03);
		// buffer still full: overflow
		gframe(8'h00, 1'b0);
		sclr();
		cfg = '{1'b1, MODE_SLAVE10, 1'b1, 1'b1, 8'h64};
		gframe(8'h00, 1'b1);
		chk(8'(status.update_address_flag), 8'h00);
		sclr();
		gframe(8'h64, 1'b1);
		chk(8'(status.update_address_flag), 8'h01);
		sclr();
		cfg = '{1'b1, MODE_SLAVE7, 1'b0, 1'b0, 8'h64};
		gframe(8'h00, 1'b0);
		chk(8'(status.buffer_full_flag), 8'h00);
		cfg.port_enable_bit = 1'b0;
		// disable needs a few slow link periods to cross
		tick(80);
		chk(8'({status.start_seen, status.stop_seen}), 8'h00);
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		rstn = 1'b0;
		req = '0;
		stretch = 1'b0;
		tb_scl_oe = 1'b0;
		tb_sda_oe = 1'b0;
		cfg = '{1'b1, MODE_MASTER, 1'b0, 1'b0, 8'h02};
		tick(8);
		rstn = 1'b1;
		// link side leaves its stretched reset well after release
		tick(120);
		t_master();
		t_slave();
		stop_test();
	end
endmodule // test_i2c_master_gencall_brg
